// *** verilog/mpmou_defines.vh ***
// Constants shared by the memory ordering unit.
`ifndef MPMOU_DEFINES_VH
`define MPMOU_DEFINES_VH
// ----------------------------------------------------------------------
// Operation codes on the issue port
// ----------------------------------------------------------------------
`define MPMOU_OP_LOAD   3'h0
`define MPMOU_OP_STORE  3'h1
`define MPMOU_OP_FENCE  3'h2
`define MPMOU_OP_SWAP   3'h3
`define MPMOU_OP_LOCKED 3'h4
`define MPMOU_OP_STRLD  3'h5
// ----------------------------------------------------------------------
// Widths and sizes
// ----------------------------------------------------------------------
`define MPMOU_ADDR_W    32
`define MPMOU_DATA_W    32
`define MPMOU_SB_DEPTH  8
`define MPMOU_PTR_W     3
`endif

// *** verilog/mpmou_sb_mem.v ***
// Store buffer storage with registered read data.
`timescale 1ns/1ns
module mpmou_sb_mem #(
    parameter AW = 3,
    parameter W  = 68
) (
    input  wire          clk,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_idx,
    input  wire [W-1:0]  wr_data,
    input  wire [AW-1:0] rd_idx,
    output reg  [W-1:0]  rd_data
);
    reg [W-1:0] mem [0:(1<<AW)-1];
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
        rd_data <= mem[rd_idx];
    end
endmodule

// *** verilog/mpmou_core.v ***
// Load/store ordering unit: store buffer, bypass, fences and locks.
//
// Behaviour
// RULE_01: Guarantees target cacheable, aligned, write-back memory accesses.
// RULE_02: Local loads, stores and instructions appear in program order.
// RULE_03: Stores commit to memory strictly in program order.
// RULE_04: A store never commits before earlier loads have their data.
// RULE_05: Loads are not reordered relative to earlier loads.
// RULE_06: String-operation loads may relax load-to-load ordering.
// RULE_07: Stores may sit in the buffer arbitrarily while execution goes on.
// RULE_08: Successive stores to one location may merge in the buffer.
// RULE_09: Non-overlapping loads may go before older buffered stores.
// RULE_10: A full fence drains all buffered stores before later loads.
// RULE_11: Locked or swap operations act as full barriers, no bypass.
// RULE_12: Partial overlap merges buffered bytes with memory bytes.
// RULE_13: Stores become visible in one single order to all observers.
// RULE_14: Causality between observed and later stores is preserved.
// RULE_15: Local loads may read forwarded buffered store data.
// RULE_16: No fixed relation between cross-processor visibility times.
// RULE_17: Same-location loads stall or receive forwarded store data.
// RULE_18: Buffer drains first-in first-out; barriers stall until empty.
`timescale 1ns/1ns
`include "mpmou_defines.vh"
module mpmou_core #(
    parameter DEPTH = `MPMOU_SB_DEPTH,
    parameter PW    = `MPMOU_PTR_W
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire        iss_valid,
    input  wire [2:0]  iss_op,
    input  wire [31:0] iss_addr,
    input  wire [3:0]  iss_be,
    input  wire [31:0] iss_wdata,
    output reg         iss_ready,
    output reg         ld_done,
    output reg  [31:0] ld_data,
    output reg         sw_old_valid,
    output reg         mem_rd_req,
    output reg  [31:0] mem_rd_addr,
    input  wire        mem_rd_ack,
    input  wire [31:0] mem_rd_data,
    output reg         mem_wr_req,
    output reg  [31:0] mem_wr_addr,
    output reg  [3:0]  mem_wr_be,
    output reg  [31:0] mem_wr_data,
    output reg         mem_lock,
    input  wire        mem_wr_ack,
    output reg         sb_empty
);
// ----------------------------------------------------------------------
// State and store buffer
// ----------------------------------------------------------------------
    localparam ST_IDLE  = 3'h0;
    localparam ST_LOAD  = 3'h1;
    localparam ST_DRAIN = 3'h2;
    localparam ST_LRD   = 3'h3;
    localparam ST_LWR   = 3'h4;
    localparam EW = 68;

    reg  [2:0]     state;
    reg  [PW:0]    count;
    reg  [PW-1:0]  head;
    reg  [PW-1:0]  tail;
    reg  [31:0]    sb_addr [0:DEPTH-1];
    reg  [3:0]     sb_be   [0:DEPTH-1];
    reg  [31:0]    sb_data [0:DEPTH-1];
    reg  [2:0]     pend_op;
    reg  [31:0]    pend_addr;
    reg  [3:0]     pend_be;
    reg  [31:0]    pend_wdata;
    reg  [31:0]    fwd_data;
    reg  [3:0]     fwd_mask;
    reg            wr_busy;
    reg            mem_fetch;
    wire [EW-1:0]  rd_entry;
    wire           full;
    wire           pop;
    wire           merge_hit;
    wire [PW-1:0]  last;
    reg  [31:0]    merge_data;
    reg            rd_fresh;
    wire           sb_wr;
    wire [PW-1:0]  sb_widx;
    wire [EW-1:0]  sb_wentry;
    wire [31:0]    look_addr;

    assign full = (count == DEPTH);
    assign last = tail - {{(PW-1){1'b0}}, 1'b1};
    // Merging only into the youngest entry keeps commit order intact.
    // The head entry may leave for memory at any edge, so it never merges.
    assign merge_hit = (count != 0) && !wr_busy_last(head, last, 1'b1)
                     && (sb_addr[last] == iss_addr); // [RULE_08] [RULE_03]
    assign sb_wr     = (state == ST_IDLE) && iss_valid && iss_ready
                     && (iss_op == `MPMOU_OP_STORE);
    assign sb_widx   = merge_hit ? last : tail;
    assign sb_wentry = merge_hit ? {sb_be[last] | iss_be, iss_addr, merge_data}
                                 : {iss_be, iss_addr, iss_wdata};
    // A load waiting on memory keeps searching for its own address.
    assign look_addr = (state == ST_IDLE) ? iss_addr : pend_addr;
    assign pop = wr_busy && mem_wr_ack;

    function wr_busy_last;
        input [PW-1:0] h;
        input [PW-1:0] l;
        input          b;
        begin
            wr_busy_last = b && (h == l);
        end
    endfunction

    function [31:0] byte_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  m;
        integer k;
        begin
            byte_merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (m[k]) begin
                    byte_merge[k*8 +: 8] = new_v[k*8 +: 8];
                end
            end
        end
    endfunction

    mpmou_sb_mem #(
        .AW (PW),
        .W  (EW)
    ) u_shadow (
        .clk     (clk),
        .wr_en   (sb_wr),
        .wr_idx  (sb_widx),
        .wr_data (sb_wentry),
        .rd_idx  (head),
        .rd_data (rd_entry)
    );

// ----------------------------------------------------------------------
// Forwarding search, oldest to youngest so younger bytes win
// ----------------------------------------------------------------------
    integer i;
    reg [PW-1:0] idx;
    always @* begin
        fwd_data = 32'h0;
        fwd_mask = 4'h0;
        idx      = head;
        for (i = 0; i < DEPTH; i = i + 1) begin
            idx = head + i[PW-1:0];
            if ((i < count) && (sb_addr[idx] == look_addr)) begin
                fwd_data = byte_merge(fwd_data, sb_data[idx], sb_be[idx]);
                fwd_mask = fwd_mask | sb_be[idx]; // [RULE_15] [RULE_12]
            end
        end
        merge_data = byte_merge(sb_data[last], iss_wdata, iss_be);
    end

// ----------------------------------------------------------------------
// Issue control
// ----------------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state        <= ST_IDLE;
            count        <= {(PW+1){1'b0}};
            head         <= {PW{1'b0}};
            tail         <= {PW{1'b0}};
            iss_ready    <= 1'b0;
            ld_done      <= 1'b0;
            ld_data      <= 32'h0;
            sw_old_valid <= 1'b0;
            mem_rd_req   <= 1'b0;
            mem_rd_addr  <= 32'h0;
            mem_wr_req   <= 1'b0;
            mem_wr_addr  <= 32'h0;
            mem_wr_be    <= 4'h0;
            mem_wr_data  <= 32'h0;
            mem_lock     <= 1'b0;
            sb_empty     <= 1'b1;
            wr_busy      <= 1'b0;
            mem_fetch    <= 1'b0;
            pend_op      <= 3'h0;
            pend_addr    <= 32'h0;
            pend_be      <= 4'h0;
            pend_wdata   <= 32'h0;
            rd_fresh     <= 1'b0;
        end else begin
            ld_done      <= 1'b0;
            sw_old_valid <= 1'b0;
            // Registered read of the head is stale one edge after it moves.
            rd_fresh     <= !pop && !(sb_wr && (sb_widx == head));
            // Drain FIFO order; a locked sequence owns the write port.
            // Stores leave whenever the port is free, with no cross-core
            // timing relation. [RULE_16]
            if (pop) begin
                wr_busy    <= 1'b0;
                mem_wr_req <= 1'b0;
                head       <= head + {{(PW-1){1'b0}}, 1'b1}; // [RULE_18]
            end else if (!wr_busy && count != 0 && state != ST_LWR
                         && rd_fresh) begin
                wr_busy     <= 1'b1;
                mem_wr_req  <= 1'b1; // [RULE_03] [RULE_13] [RULE_14]
                mem_wr_addr <= rd_entry[63:32];
                mem_wr_be   <= rd_entry[67:64];
                mem_wr_data <= rd_entry[31:0];
            end
            case (state)
            ST_IDLE: begin
                // A full buffer keeps issue closed until an entry leaves.
                iss_ready <= !full || pop;
                if (iss_valid && iss_ready) begin
                    pend_op    <= iss_op;
                    pend_addr  <= iss_addr;
                    pend_be    <= iss_be;
                    pend_wdata <= iss_wdata;
                    case (iss_op)
                    `MPMOU_OP_STORE: begin
                        // Stores enter only after earlier loads completed.
                        if (merge_hit) begin
                            sb_data[last] <= merge_data; // [RULE_08]
                            sb_be[last]   <= sb_be[last] | iss_be;
                        end else begin
                            sb_addr[tail] <= iss_addr; // [RULE_04] [RULE_07]
                            sb_be[tail]   <= iss_be;
                            sb_data[tail] <= iss_wdata;
                            tail <= tail + {{(PW-1){1'b0}}, 1'b1};
                        end
                        if (!merge_hit && (count + 1'b1 == DEPTH)) begin
                            iss_ready <= 1'b0;
                        end
                    end
                    `MPMOU_OP_LOAD, `MPMOU_OP_STRLD: begin // [RULE_06]
                        iss_ready <= 1'b0;
                        if ((fwd_mask & iss_be) == iss_be) begin
                            ld_done <= 1'b1; // [RULE_15] [RULE_17]
                            ld_data <= fwd_data;
                            iss_ready <= 1'b1;
                        end else begin
                            // Partial or no overlap reads memory first.
                            state       <= ST_LOAD; // [RULE_09] [RULE_12]
                            mem_rd_req  <= 1'b1;
                            mem_fetch   <= 1'b1;
                            mem_rd_addr <= iss_addr;
                        end
                    end
                    `MPMOU_OP_FENCE, `MPMOU_OP_SWAP, `MPMOU_OP_LOCKED: begin
                        iss_ready <= 1'b0;
                        state     <= ST_DRAIN; // [RULE_10] [RULE_11]
                    end
                    default: begin
                        iss_ready <= 1'b1;
                    end
                    endcase
                end
            end
            ST_LOAD: begin
                // One load in flight keeps loads in order.
                if (mem_rd_ack) begin
                    mem_rd_req <= 1'b0;
                    mem_fetch  <= 1'b0;
                    ld_done    <= 1'b1; // [RULE_05] [RULE_02]
                    ld_data    <= byte_merge(mem_rd_data, fwd_data,
                                             fwd_mask & pend_be);
                    iss_ready  <= !full;
                    state      <= ST_IDLE;
                end
            end
            ST_DRAIN: begin
                if (count == 0 && !wr_busy) begin // [RULE_18]
                    if (pend_op == `MPMOU_OP_FENCE) begin
                        iss_ready <= 1'b1;
                        state     <= ST_IDLE; // [RULE_10]
                    end else begin
                        mem_lock    <= 1'b1; // [RULE_11] [RULE_01]
                        mem_rd_req  <= 1'b1;
                        mem_rd_addr <= pend_addr;
                        state       <= ST_LRD;
                    end
                end
            end
            ST_LRD: begin
                if (mem_rd_ack) begin
                    mem_rd_req   <= 1'b0;
                    ld_data      <= mem_rd_data;
                    sw_old_valid <= 1'b1;
                    mem_wr_req   <= 1'b1;
                    mem_wr_addr  <= pend_addr;
                    mem_wr_be    <= pend_be;
                    mem_wr_data  <= pend_wdata;
                    state        <= ST_LWR;
                end
            end
            ST_LWR: begin
                // Written straight to memory, never through the buffer.
                if (mem_wr_ack) begin
                    mem_wr_req <= 1'b0;
                    mem_lock   <= 1'b0;
                    iss_ready  <= 1'b1;
                    state      <= ST_IDLE; // [RULE_11]
                end
            end
            default: begin
                state <= ST_IDLE;
            end
            endcase
            count <= count
                   + ((state == ST_IDLE && iss_valid && iss_ready
                       && iss_op == `MPMOU_OP_STORE && !merge_hit)
                      ? {{PW{1'b0}}, 1'b1} : {(PW+1){1'b0}})
                   - (pop && state != ST_LWR
                      ? {{PW{1'b0}}, 1'b1} : {(PW+1){1'b0}});
            sb_empty <= (count == 0);
        end
    end
endmodule

// *** testbench/mpmou_checker.sv ***
// Port checks for the memory ordering unit.
`timescale 1ns/1ns
`include "mpmou_defines.vh"
module mpmou_checker (
    input wire        clk,
    input wire        rstn,
    input wire        iss_valid,
    input wire [2:0]  iss_op,
    input wire        iss_ready,
    input wire        ld_done,
    input wire        sw_old_valid,
    input wire        mem_rd_req,
    input wire [31:0] mem_rd_addr,
    input wire        mem_rd_ack,
    input wire        mem_wr_req,
    input wire [31:0] mem_wr_addr,
    input wire [31:0] mem_wr_data,
    input wire        mem_lock,
    input wire        mem_wr_ack
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire take = iss_valid && iss_ready;
    wire ldop = iss_op == `MPMOU_OP_LOAD || iss_op == `MPMOU_OP_STRLD;
    a_wr_req_hold: assert property (mem_wr_req && !mem_wr_ack |=>
        mem_wr_req && $stable(mem_wr_addr) && $stable(mem_wr_data))
        else $error("store request changed before ack");
    a_rd_req_hold: assert property (mem_rd_req && !mem_rd_ack |=>
        mem_rd_req && $stable(mem_rd_addr))
        else $error("load request changed before ack");
    a_wr_release: assert property (mem_wr_ack |=> !mem_wr_req)
        else $error("store request held after ack");
    a_rd_to_done: assert property (mem_rd_ack && !mem_lock |=> ld_done)
        else $error("load result missing after ack");
    a_swap_old: assert property (mem_rd_ack && mem_lock |=> sw_old_valid)
        else $error("swap old value missing");
    a_old_locked: assert property (sw_old_valid |-> mem_lock)
        else $error("swap result outside lock");
    a_lock_drained: assert property ($rose(mem_lock) |-> !mem_wr_req)
        else $error("lock taken with store pending");
    a_barrier_stall: assert property (
        take && (iss_op == `MPMOU_OP_FENCE || iss_op == `MPMOU_OP_SWAP
                 || iss_op == `MPMOU_OP_LOCKED) |=> !iss_ready)
        else $error("issue open during blocking op");
    a_ld_cause: assert property (ld_done |->
        $past(mem_rd_ack) || $past(take && ldop))
        else $error("load result without cause");
endmodule

// *** testbench/mpmou_mem_model.sv ***
// Coherent memory model answering the unit's read and write requests.
`timescale 1ns/1ns
module mpmou_mem_model (
    input  wire        clk,
    input  wire        rstn,
    input  wire [3:0]  lat,
    input  wire        mem_rd_req,
    input  wire [31:0] mem_rd_addr,
    output logic       mem_rd_ack,
    output logic [31:0] mem_rd_data,
    input  wire        mem_wr_req,
    input  wire [31:0] mem_wr_addr,
    input  wire [3:0]  mem_wr_be,
    input  wire [31:0] mem_wr_data,
    output logic       mem_wr_ack
);
    logic [31:0] mem [0:15];
    logic [31:0] wr_log [0:15];
    logic [3:0]  wr_n, rcnt, wcnt;
    // Memory starts all zero, as the ordering examples assume.
    initial for (int i = 0; i < 16; i++) mem[i] = 32'h0;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_rd_ack <= 1'b0;
            mem_wr_ack <= 1'b0;
            mem_rd_data <= 32'h0;
            {wr_n, rcnt, wcnt} <= 12'h0;
        end else begin
            mem_rd_ack <= 1'b0;
            mem_wr_ack <= 1'b0;
            // Stale data is inverted so a late sample cannot look right.
            if (mem_rd_ack) mem_rd_data <= ~mem_rd_data;
            else if (mem_rd_req && rcnt == lat) begin
                mem_rd_ack <= 1'b1;
                mem_rd_data <= mem[mem_rd_addr[5:2]];
                rcnt <= 4'h0;
            end else if (mem_rd_req) rcnt <= rcnt + 4'h1;
            // One array gives every observer one store order.
            if (!mem_wr_ack && mem_wr_req && wcnt == lat) begin
                mem_wr_ack <= 1'b1;
                wcnt <= 4'h0;
                wr_log[wr_n] <= mem_wr_addr;
                wr_n <= wr_n + 4'h1;
                for (int k = 0; k < 4; k++)
                    if (mem_wr_be[k])
                        mem[mem_wr_addr[5:2]][8*k+:8] <= mem_wr_data[8*k+:8];
            end else if (!mem_wr_ack && mem_wr_req) wcnt <= wcnt + 4'h1;
        end
    end
endmodule

// *** testbench/tb_top.sv ***
// Scenario testbench for the memory ordering unit.
`timescale 1ns/1ns
`include "mpmou_defines.vh"
module tb_top;
    logic        clk, rstn, iss_valid, mem_rd_ack, mem_wr_ack;
    logic        iss_ready, ld_done, sw_old_valid, mem_rd_req;
    logic        mem_wr_req, mem_lock, sb_empty;
    logic [2:0]  iss_op;
    logic [3:0]  iss_be, mem_wr_be, lat;
    logic [31:0] iss_addr, iss_wdata, ld_data, mem_rd_addr, mem_rd_data;
    logic [31:0] mem_wr_addr, mem_wr_data, v;
    int          errors, n_checks, n0;
    mpmou_core u_mpmou_core (.clk, .rstn, .iss_valid, .iss_op, .iss_addr,
        .iss_be, .iss_wdata, .iss_ready, .ld_done, .ld_data, .sw_old_valid,
        .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .mem_wr_req,
        .mem_wr_addr, .mem_wr_be, .mem_wr_data, .mem_lock, .mem_wr_ack,
        .sb_empty);
    mpmou_mem_model u_mpmou_mem_model (.clk, .rstn, .lat, .mem_rd_req,
        .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .mem_wr_req, .mem_wr_addr,
        .mem_wr_be, .mem_wr_data, .mem_wr_ack);
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Leaves valid high so stores can go back to back.
    task automatic issue(input logic [2:0] op, input logic [31:0] a, d,
                         input logic [3:0] be = 4'hf);
        int n;
        logic r;
        n = 0;
        iss_valid <= 1'b1;
        iss_op <= op;
        iss_addr <= a;
        iss_be <= be;
        iss_wdata <= d;
        do begin
            @(negedge clk);
            r = iss_ready;
            @(posedge clk);
            n++;
        end while (r !== 1'b1 && n < 400);
        if (r !== 1'b1) chk("issue accepted", 1, 0);
    endtask
    task automatic get(input logic [31:0] e, input string nm);
        int n;
        n = 0;
        iss_valid <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (ld_done !== 1'b1 && sw_old_valid !== 1'b1 && n < 400);
        if (ld_done !== 1'b1 && sw_old_valid !== 1'b1)
            chk("result strobe", 1, 0);
        chk(nm, e, ld_data);
        @(posedge clk);
    endtask
    // Returns only once issue reopens, which is after the buffer drained.
    task automatic fence();
        int n;
        n = 0;
        issue(`MPMOU_OP_FENCE, 0, 0);
        iss_valid <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (iss_ready !== 1'b1 && n < 400);
        chk("fence release", 1, iss_ready);
        @(posedge clk);
    endtask
    task automatic t_order();
        lat <= 4'h3;
        n0 = u_mpmou_mem_model.wr_n;
        issue(`MPMOU_OP_STORE, 32'h10, 32'h1);
        issue(`MPMOU_OP_STORE, 32'h14, 32'h2);
        issue(`MPMOU_OP_STORE, 32'h18, 32'h3);
        issue(`MPMOU_OP_STORE, 32'h1c, 32'h5);
        issue(`MPMOU_OP_STORE, 32'h1c, 32'h6);
        fence();
        chk("first commit", 32'h10, u_mpmou_mem_model.wr_log[n0]);
        chk("second commit", 32'h14, u_mpmou_mem_model.wr_log[n0+1]);
        chk("third commit", 32'h18, u_mpmou_mem_model.wr_log[n0+2]);
        chk("drained word", 32'h3, u_mpmou_mem_model.mem[6]);
        chk("combined word", 32'h6, u_mpmou_mem_model.mem[7]);
        chk("commit count", 4, u_mpmou_mem_model.wr_n - n0);
        chk("buffer empty", 1, sb_empty);
    endtask
    task automatic t_bypass();
        lat <= 4'h6;
        issue(`MPMOU_OP_STORE, 32'h20, 32'ha5a5a5a5);
        issue(`MPMOU_OP_LOAD, 32'h20, 0);
        get(32'ha5a5a5a5, "forwarded load");
        issue(`MPMOU_OP_LOAD, 32'h24, 0);
        get(32'h0, "load past store");
        issue(`MPMOU_OP_STORE, 32'h24, 32'h11223344);
        fence();
        issue(`MPMOU_OP_STORE, 32'h24, 32'h000000aa, 4'h1);
        issue(`MPMOU_OP_LOAD, 32'h24, 0);
        get(32'h112233aa, "merged load");
        issue(`MPMOU_OP_STRLD, 32'h14, 0);
        get(32'h2, "string load");
        fence();
    endtask
    task automatic t_swap();
        lat <= 4'h1;
        issue(`MPMOU_OP_STORE, 32'h28, 32'h7);
        issue(`MPMOU_OP_SWAP, 32'h28, 32'h9);
        get(32'h7, "swap old value");
        issue(`MPMOU_OP_LOCKED, 32'h28, 32'hc);
        get(32'h9, "locked old value");
        issue(`MPMOU_OP_LOAD, 32'h28, 0);
        get(32'hc, "load after lock");
        chk("locked word", 32'hc, u_mpmou_mem_model.mem[10]);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {rstn, iss_valid, iss_op, iss_be, iss_addr, iss_wdata} = '0;
        lat = 4'h0;
        errors = 0;
        n_checks = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        t_order();
        t_bypass();
        t_swap();
        summarize();
    end
    // A hang is cut after far more time than the scenarios need.
    initial begin
        #100000;
        errors++;
        summarize();
    end
endmodule
bind mpmou_core mpmou_checker u_mpmou_checker (.clk, .rstn, .iss_valid,
    .iss_op, .iss_ready, .ld_done, .sw_old_valid, .mem_rd_req, .mem_rd_addr,
    .mem_rd_ack, .mem_wr_req, .mem_wr_addr, .mem_wr_data, .mem_lock,
    .mem_wr_ack);
